// ---- design/asb_pkg.sv ----
package asb_pkg;
  // Trigger source codes
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_EXT_PIN = 3'h1;
  localparam logic [2:0] TRIG_TIMER = 3'h2;
  localparam logic [2:0] TRIG_EXT_ALT = 3'h3;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  // Conversion timing
  localparam int CONV_PERIODS = 12;
  localparam logic [3:0] CONV_LAST = 4'hb;
  // Buffer geometry
  localparam int BUF_WORDS = 16;
  localparam logic [3:0] HALF_LAST = 4'h7;
  localparam logic [3:0] SECOND_HALF_BASE = 4'h8;
  // Reset values
  localparam logic [3:0] SLOT_RST = 4'h0;
  localparam logic [7:0] PRESCALE_CNT_RST = 8'h00;
  // Sequencer states
  typedef enum logic [1:0]
  {
    ASB_IDLE = 2'b00,
    ASB_SAMPLE = 2'b01,
    ASB_CONVERT = 2'b11
  } asb_state_e;
endpackage

// ---- design/asb_result_mem.sv ----
module asb_result_mem #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_we,
  input wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge i_ref_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    o_rdata <= mem[i_raddr];
  end
endmodule

// ---- design/asb_sequencer.sv ----
// What this block does
// - External trigger codes with auto sampling end sampling and start conversion on pulse.
// - Timer trigger with auto sampling starts every conversion on timer compare event.
// - Without auto sampling, acquisition starts only when software sets sample bit.
// - With auto sampling, new acquisition starts right after the previous conversion.
// - Three-bit reference field picks upper and lower references, rails or pins.
// - Scan enabled: mux A positive input steps through inputs set in scan map.
// - Scan with alternate affects mux A only; mux B keeps its own selects.
// - Samples-per-irq field sets conversions per interrupt: 1-16 single, 1-8 split.
// - After interrupt the sequence restarts at the first slot of current region.
// - Single mode uses 16 words from word 0, wrapping to word 0 at count.
// - Split mode fills first half from word 0, indicator clear, flag at count.
// - Split mode then fills second half from word 8, indicator set, then returns.
// - Four-bit mux A positive field selects one of 16 analog inputs.
// - Mux A negative bit selects lower reference or analog input one.
// - Alternate bit toggles mux A and mux B per sample; else only mux A.
// - Clock source bit one uses RC oscillator period directly as conversion clock.
// - Clock source zero: period is two bus clocks times prescale plus one.
// - Each conversion ends on the twelfth conversion clock tick after it starts.
// - Trigger code 000 ends sampling when software clears the sample bit.
// - Trigger code 001 converts on the programmed edge of the external pin.
// - Trigger code 010 converts on the timer period-match trigger event.
// - Trigger code 111 counts programmed conversion clocks from acquisition, then converts.
module asb_sequencer #(
  parameter int RES_WIDTH = 10
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_enable,
  input wire logic [2:0] i_trigger_source_sel,
  input wire logic i_auto_sample_en,
  input wire logic i_sample_bit,
  input wire logic [2:0] i_reference_cfg,
  input wire logic i_scan_enable_bit,
  input wire logic [15:0] i_scan_select_map,
  input wire logic i_alternate_mux_bit,
  input wire logic [3:0] i_mux_a_positive_sel,
  input wire logic i_mux_a_negative_sel,
  input wire logic [3:0] i_mux_b_positive_sel,
  input wire logic i_mux_b_negative_sel,
  input wire logic [3:0] i_samples_per_irq,
  input wire logic i_buffer_split_bit,
  input wire logic i_conv_clock_source_bit,
  input wire logic [7:0] i_conv_clock_prescale,
  input wire logic [4:0] i_auto_sample_time,
  input wire logic i_rc_osc_tick,
  input wire logic i_external_irq_zero_pin,
  input wire logic i_ext_edge_rising,
  input wire logic i_timer_trigger,
  input wire logic i_alt_trigger,
  input wire logic i_flag_clear,
  input wire logic i_core_result_valid,
  input wire logic [RES_WIDTH-1:0] i_core_result,
  input wire logic [3:0] i_read_addr,
  output logic o_sampling,
  output logic o_converting,
  output logic o_conv_clock,
  output logic o_conv_start,
  output logic [3:0] o_pos_input,
  output logic o_neg_is_input_one,
  output logic o_upper_ref_ext,
  output logic o_lower_ref_ext,
  output logic o_irq_flag,
  output logic o_buffer_half_indicator,
  output logic o_sample_bit_clear,
  output logic [RES_WIDTH-1:0] o_read_data
);
  // ---------------------------------------------------------------
  // Conversion clock
  // ---------------------------------------------------------------
  logic [7:0] prescale_cnt;
  logic half_tick;
  logic tad_tick;
  logic tad_phase;

  // Conversion clock half period spans prescale+1 bus cycles; two halves per period
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      prescale_cnt <= asb_pkg::PRESCALE_CNT_RST;
    end
    else if (half_tick)
    begin
      prescale_cnt <= asb_pkg::PRESCALE_CNT_RST;
    end
    else
    begin
      prescale_cnt <= prescale_cnt + 8'h01;
    end
  end

  assign half_tick = (prescale_cnt == i_conv_clock_prescale);

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tad_phase <= 1'b0;
    end
    else if (i_conv_clock_source_bit ? i_rc_osc_tick : half_tick)
    begin
      tad_phase <= ~tad_phase;
    end
  end

  // RC tick is one full period; bus path ticks on every second half
  assign tad_tick = i_conv_clock_source_bit ? i_rc_osc_tick
                  : (half_tick && tad_phase);

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_conv_clock <= 1'b0;
    end
    else
    begin
      o_conv_clock <= i_conv_clock_source_bit ? i_rc_osc_tick : tad_phase;
    end
  end

  // ---------------------------------------------------------------
  // Trigger selection
  // ---------------------------------------------------------------
  logic pin_prev;
  logic sample_prev;
  logic [4:0] auto_cnt;
  logic [3:0] conv_cnt;
  logic trigger;
  asb_pkg::asb_state_e state;

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pin_prev <= 1'b0;
      sample_prev <= 1'b0;
    end
    else
    begin
      pin_prev <= i_external_irq_zero_pin;
      sample_prev <= i_sample_bit;
    end
  end

  always_comb
  begin
    trigger = 1'b0;
    unique case (i_trigger_source_sel)
      asb_pkg::TRIG_MANUAL: trigger = sample_prev && !i_sample_bit;
      asb_pkg::TRIG_EXT_PIN: trigger = i_ext_edge_rising
                                     ? (i_external_irq_zero_pin && !pin_prev)
                                     : (!i_external_irq_zero_pin && pin_prev);
      asb_pkg::TRIG_TIMER: trigger = i_timer_trigger;
      asb_pkg::TRIG_EXT_ALT: trigger = i_alt_trigger;
      asb_pkg::TRIG_AUTO: trigger = tad_tick && (auto_cnt >= i_auto_sample_time);
      default: trigger = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Sample and convert sequencer
  // ---------------------------------------------------------------
  logic conv_done;
  assign conv_done = (state == asb_pkg::ASB_CONVERT) && tad_tick
                   && (conv_cnt == asb_pkg::CONV_LAST);

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= asb_pkg::ASB_IDLE;
    end
    else if (!i_enable)
    begin
      state <= asb_pkg::ASB_IDLE;
    end
    else
    begin
      unique case (state)
        asb_pkg::ASB_IDLE:
          if (i_auto_sample_en || (i_sample_bit && !sample_prev))
          begin
            state <= asb_pkg::ASB_SAMPLE;
          end
        asb_pkg::ASB_SAMPLE:
          if (trigger)
          begin
            state <= asb_pkg::ASB_CONVERT;
          end
        asb_pkg::ASB_CONVERT:
          if (conv_done)
          begin
            state <= i_auto_sample_en ? asb_pkg::ASB_SAMPLE : asb_pkg::ASB_IDLE;
          end
        default: state <= asb_pkg::ASB_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      auto_cnt <= 5'h00;
    end
    else if (state != asb_pkg::ASB_SAMPLE)
    begin
      auto_cnt <= 5'h00;
    end
    else if (tad_tick && auto_cnt != 5'h1f)
    begin
      auto_cnt <= auto_cnt + 5'h01;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      conv_cnt <= 4'h0;
    end
    else if (state != asb_pkg::ASB_CONVERT)
    begin
      conv_cnt <= 4'h0;
    end
    else if (tad_tick)
    begin
      conv_cnt <= conv_cnt + 4'h1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_sampling <= 1'b0;
      o_converting <= 1'b0;
      o_conv_start <= 1'b0;
      o_sample_bit_clear <= 1'b0;
    end
    else
    begin
      o_sampling <= (state == asb_pkg::ASB_SAMPLE);
      o_converting <= (state == asb_pkg::ASB_CONVERT);
      o_conv_start <= (state == asb_pkg::ASB_SAMPLE) && trigger && i_enable;
      // Hardware drops the sample bit once its conversion starts under non-manual triggers
      o_sample_bit_clear <= (state == asb_pkg::ASB_SAMPLE) && trigger && i_enable
                            && (i_trigger_source_sel != asb_pkg::TRIG_MANUAL);
    end
  end

  // ---------------------------------------------------------------
  // Input selection
  // ---------------------------------------------------------------
  logic use_mux_b;
  logic [3:0] scan_ptr;
  logic [3:0] scan_next;
  logic [3:0] scan_first;
  logic seq_end;

  always_comb
  begin
    scan_next = scan_ptr;
    scan_first = scan_ptr;
    for (int k = 15; k >= 0; k--)
    begin
      if (i_scan_select_map[k])
      begin
        scan_first = 4'(k);
      end
    end
    scan_next = scan_first;
    for (int k = 15; k >= 0; k--)
    begin
      if (i_scan_select_map[k] && (4'(k) > scan_ptr))
      begin
        scan_next = 4'(k);
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      use_mux_b <= 1'b0;
      scan_ptr <= 4'h0;
    end
    else if (!i_enable)
    begin
      use_mux_b <= 1'b0;
      scan_ptr <= scan_first;
    end
    else if (conv_done)
    begin
      use_mux_b <= i_alternate_mux_bit && !use_mux_b;
      if (!use_mux_b)
      begin
        scan_ptr <= seq_end ? scan_first : scan_next;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_pos_input <= 4'h0;
      o_neg_is_input_one <= 1'b0;
      o_upper_ref_ext <= 1'b0;
      o_lower_ref_ext <= 1'b0;
    end
    else
    begin
      if (use_mux_b)
      begin
        o_pos_input <= i_mux_b_positive_sel;
        o_neg_is_input_one <= i_mux_b_negative_sel;
      end
      else
      begin
        o_pos_input <= i_scan_enable_bit ? scan_ptr : i_mux_a_positive_sel;
        o_neg_is_input_one <= i_mux_a_negative_sel;
      end
      o_upper_ref_ext <= i_reference_cfg[0];
      o_lower_ref_ext <= i_reference_cfg[1];
    end
  end

  // ---------------------------------------------------------------
  // Result buffer fill
  // ---------------------------------------------------------------
  logic [3:0] slot;
  logic [3:0] count_last;

  // Split mode tops out at eight per half
  assign count_last = (i_buffer_split_bit && i_samples_per_irq > asb_pkg::HALF_LAST)
                    ? asb_pkg::HALF_LAST : i_samples_per_irq;
  assign seq_end = (slot == count_last);

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      slot <= asb_pkg::SLOT_RST;
      o_buffer_half_indicator <= 1'b0;
    end
    else if (!i_enable)
    begin
      slot <= asb_pkg::SLOT_RST;
      o_buffer_half_indicator <= 1'b0;
    end
    else if (i_core_result_valid && seq_end)
    begin
      slot <= asb_pkg::SLOT_RST;
      o_buffer_half_indicator <= i_buffer_split_bit && !o_buffer_half_indicator;
    end
    else if (i_core_result_valid)
    begin
      slot <= slot + 4'h1;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_irq_flag <= 1'b0;
    end
    else if (i_core_result_valid && seq_end && i_enable)
    begin
      o_irq_flag <= 1'b1;
    end
    else if (i_flag_clear)
    begin
      o_irq_flag <= 1'b0;
    end
  end

  logic [3:0] waddr;
  assign waddr = (i_buffer_split_bit && o_buffer_half_indicator)
               ? (asb_pkg::SECOND_HALF_BASE | slot) : slot;

  asb_result_mem #(
    .WIDTH(RES_WIDTH),
    .DEPTH(asb_pkg::BUF_WORDS)
  ) u_mem (
    .i_ref_clk(i_ref_clk),
    .i_we(i_core_result_valid && i_enable),
    .i_waddr(waddr),
    .i_wdata(i_core_result),
    .i_raddr(i_read_addr),
    .o_rdata(o_read_data)
  );
endmodule

// ---- verif/asb_sequencer_monitor.sv ----
// ----------------------------------------
// Port checker for the sequencer
// ----------------------------------------
module asb_sequencer_monitor (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_enable,
  input wire logic [2:0] i_trigger_source_sel,
  input wire logic i_auto_sample_en,
  input wire logic i_sample_bit,
  input wire logic [2:0] i_reference_cfg,
  input wire logic i_conv_clock_source_bit,
  input wire logic [7:0] i_conv_clock_prescale,
  input wire logic i_timer_trigger,
  input wire logic i_core_result_valid,
  input wire logic o_sampling,
  input wire logic o_converting,
  input wire logic o_conv_start,
  input wire logic o_upper_ref_ext,
  input wire logic o_lower_ref_ext,
  input wire logic o_irq_flag,
  input wire logic o_buffer_half_indicator
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] conv_len;
  logic [1:0] ref_pair;
  assign ref_pair = i_reference_cfg[1:0];
  // Cycles spent converting so far
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      conv_len <= 16'h0000;
    else if (o_converting)
      conv_len <= conv_len + 16'h0001;
    else
      conv_len <= 16'h0000;
  end
  default clocking mon_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);
  a_manual_clear_starts: assert property ($fell(i_sample_bit) && o_sampling && i_enable
    && i_trigger_source_sel == asb_pkg::TRIG_MANUAL |-> ##[1:3] o_conv_start)
    else $error("manual clear did not start a conversion");
  a_timer_event_starts: assert property (i_timer_trigger && o_sampling && i_enable
    && i_auto_sample_en && i_trigger_source_sel == asb_pkg::TRIG_TIMER |-> ##[1:3] o_conv_start)
    else $error("timer event did not start a conversion");
  a_reference_follows: assert property ($past(i_arst_n)
    |-> {o_lower_ref_ext, o_upper_ref_ext} == $past(ref_pair))
    else $error("reference selects do not follow the field");
  a_conv_twelve_ticks: assert property ($fell(o_converting) && i_enable && $past(i_enable)
    && $past(i_enable, 2) && !i_conv_clock_source_bit
    |-> conv_len >= 22 * (i_conv_clock_prescale + 1) + 1
    && conv_len <= 24 * (i_conv_clock_prescale + 1) + 2)
    else $error("conversion length off");
  a_flag_after_result: assert property ($rose(o_irq_flag) |-> $past(i_core_result_valid))
    else $error("flag rose without a result");
  a_half_at_seq_end: assert property ($changed(o_buffer_half_indicator) && $past(i_enable)
    |-> $past(i_core_result_valid))
    else $error("half indicator moved outside a sequence end");
  a_manual_no_resume: assert property ((!o_sampling && !i_auto_sample_en && !i_sample_bit)[*3]
    |=> !o_sampling)
    else $error("sampling resumed without the sample bit");
  a_auto_resumes: assert property ($fell(o_converting) && i_auto_sample_en && i_enable
    && $past(i_enable) |-> ##[0:3] o_sampling)
    else $error("auto sampling did not resume");
endmodule
bind asb_sequencer asb_sequencer_monitor u_mon (.i_ref_clk, .i_arst_n, .i_enable,
  .i_trigger_source_sel, .i_auto_sample_en, .i_sample_bit, .i_reference_cfg,
  .i_conv_clock_source_bit, .i_conv_clock_prescale, .i_timer_trigger, .i_core_result_valid,
  .o_sampling, .o_converting, .o_conv_start, .o_upper_ref_ext, .o_lower_ref_ext, .o_irq_flag,
  .o_buffer_half_indicator);

// ---- verif/asb_core_model.sv ----
// ----------------------------------------
// Converter core stand-in
// ----------------------------------------
module asb_core_model (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_conv_start,
  input wire logic i_converting,
  input wire logic [3:0] i_pos_input,
  input wire logic i_neg_is_input_one,
  output logic o_result_valid,
  output logic [9:0] o_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] held;
  logic was_conv;
  always @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      held <= 5'h00;
      was_conv <= 1'b0;
      o_result_valid <= 1'b0;
      o_result <= 10'h000;
    end
    else
    begin
      was_conv <= i_converting;
      if (i_conv_start)
        held <= {i_neg_is_input_one, i_pos_input};
      o_result_valid <= was_conv && !i_converting;
      // Result names the sampled inputs; between results the bus keeps toggling
      o_result <= (was_conv && !i_converting) ? {5'h10, held} : ~o_result;
    end
  end
endmodule

// ---- verif/asb_sequencer_test.sv ----
// ----------------------------------------
// Sequencer testbench
// ----------------------------------------
module asb_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 1'b0, i_arst_n = 1'b0, i_enable = 1'b0, i_auto_sample_en = 1'b0;
  logic [2:0] i_trigger_source_sel = 3'h0, i_reference_cfg = 3'h0;
  logic i_sample_bit = 1'b0, i_scan_enable_bit = 1'b0, i_alternate_mux_bit = 1'b0;
  logic [15:0] i_scan_select_map = 16'h0000;
  logic [3:0] i_mux_a_positive_sel = 4'h0, i_mux_b_positive_sel = 4'h0;
  logic [3:0] i_samples_per_irq = 4'h0, i_read_addr = 4'h0;
  logic i_mux_a_negative_sel = 1'b0, i_mux_b_negative_sel = 1'b0, i_buffer_split_bit = 1'b0;
  logic i_conv_clock_source_bit = 1'b0, i_rc_osc_tick = 1'b0, i_external_irq_zero_pin = 1'b0;
  logic [7:0] i_conv_clock_prescale = 8'h00;
  logic [4:0] i_auto_sample_time = 5'h01;
  logic i_ext_edge_rising = 1'b1, i_timer_trigger = 1'b0, i_alt_trigger = 1'b0;
  logic i_flag_clear = 1'b0, i_core_result_valid;
  logic [9:0] i_core_result, o_read_data;
  logic o_sampling, o_converting, o_conv_clock, o_conv_start, o_neg_is_input_one;
  logic o_upper_ref_ext, o_lower_ref_ext, o_irq_flag, o_buffer_half_indicator;
  logic o_sample_bit_clear;
  logic [3:0] o_pos_input;
  int fail_count = 0, n_tests = 0;
  asb_sequencer u_dut (.i_ref_clk, .i_arst_n, .i_enable, .i_trigger_source_sel,
    .i_auto_sample_en, .i_sample_bit, .i_reference_cfg, .i_scan_enable_bit, .i_scan_select_map,
    .i_alternate_mux_bit, .i_mux_a_positive_sel, .i_mux_a_negative_sel, .i_mux_b_positive_sel,
    .i_mux_b_negative_sel, .i_samples_per_irq, .i_buffer_split_bit, .i_conv_clock_source_bit,
    .i_conv_clock_prescale, .i_auto_sample_time, .i_rc_osc_tick, .i_external_irq_zero_pin,
    .i_ext_edge_rising, .i_timer_trigger, .i_alt_trigger, .i_flag_clear, .i_core_result_valid,
    .i_core_result, .i_read_addr, .o_sampling, .o_converting, .o_conv_clock, .o_conv_start,
    .o_pos_input, .o_neg_is_input_one, .o_upper_ref_ext, .o_lower_ref_ext, .o_irq_flag,
    .o_buffer_half_indicator, .o_sample_bit_clear, .o_read_data);
  asb_core_model u_core (.i_ref_clk, .i_arst_n, .i_conv_start(o_conv_start),
    .i_converting(o_converting), .i_pos_input(o_pos_input), .i_neg_is_input_one(o_neg_is_input_one),
    .o_result_valid(i_core_result_valid), .o_result(i_core_result));
  always #20 i_ref_clk = ~i_ref_clk;
  // Oscillator tick every fourth cycle
  always
  begin
    repeat (3) @(posedge i_ref_clk);
    #1 i_rc_osc_tick = 1'b1;
    @(posedge i_ref_clk);
    #1 i_rc_osc_tick = 1'b0;
  end
  task automatic step(input int n = 1);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_hi(input bit irq);
    int i;
    i = 0;
    while ((irq ? o_irq_flag : o_conv_start) !== 1'b1 && i < 4000)
    begin
      step();
      i++;
    end
  endtask
  function automatic logic [9:0] word(input logic n, input logic [3:0] p);
    return {5'h10, n, p};
  endfunction
  task automatic rd(input logic [3:0] a, input logic [9:0] e);
    i_read_addr = a;
    step(2);
    check(16'(o_read_data), 16'(e));
  endtask
  task automatic t_refs();
    for (int k = 0; k < 8; k++)
    begin
      i_reference_cfg = 3'(k);
      step(2);
      check(16'({o_lower_ref_ext, o_upper_ref_ext}), 16'(k & 3));
    end
  endtask
  task automatic t_manual();
    i_mux_a_positive_sel = 4'h5;
    i_mux_a_negative_sel = 1'b1;
    i_enable = 1'b1;
    step(2);
    i_sample_bit = 1'b1;
    step(6);
    check(16'(o_sampling), 16'h1);
    i_sample_bit = 1'b0;
    wait_hi(1'b0);
    check(16'(o_conv_start), 16'h1);
    check(16'(o_sample_bit_clear), 16'h0);
    check(16'({o_neg_is_input_one, o_pos_input}), 16'h15);
    step(80);
    check(16'(o_sampling), 16'h0);
  endtask
  task automatic t_triggers();
    for (int k = 0; k < 4; k++)
    begin
      i_enable = 1'b0;
      i_trigger_source_sel = 3'(k % 3 + 1);
      i_ext_edge_rising = (k != 3);
      i_external_irq_zero_pin = (k == 3);
      i_auto_sample_en = 1'b1;
      i_sample_bit = 1'b1;
      step(2);
      i_enable = 1'b1;
      step(30);
      check(16'({o_sampling, o_converting}), 16'h2);
      case (k)
        0: i_external_irq_zero_pin = 1'b1;
        3: i_external_irq_zero_pin = 1'b0;
        1: i_timer_trigger = 1'b1;
        default: i_alt_trigger = 1'b1;
      endcase
      step();
      i_timer_trigger = 1'b0;
      i_alt_trigger = 1'b0;
      wait_hi(1'b0);
      check(16'(o_conv_start), 16'h1);
      check(16'(o_sample_bit_clear), 16'h1);
      i_external_irq_zero_pin = 1'b0;
      step(60);
    end
    i_ext_edge_rising = 1'b1;
  endtask
  task automatic run_seq(input bit split, input logic [3:0] n, input logic [15:0] map, input bit alt);
    i_enable = 1'b0;
    i_buffer_split_bit = split;
    i_samples_per_irq = n;
    i_scan_enable_bit = 1'b1;
    i_scan_select_map = map;
    i_alternate_mux_bit = alt;
    i_mux_a_negative_sel = 1'b0;
    i_auto_sample_en = 1'b1;
    i_trigger_source_sel = asb_pkg::TRIG_AUTO;
    // Drop any flag left by earlier scenarios so the wait below sees this sequence
    i_flag_clear = 1'b1;
    step(2);
    i_flag_clear = 1'b0;
    i_enable = 1'b1;
    wait_hi(1'b1);
    step();
    check(16'({o_irq_flag, o_buffer_half_indicator}), 16'(2 + split));
    i_flag_clear = 1'b1;
    step();
    i_flag_clear = 1'b0;
    if (split)
    begin
      wait_hi(1'b1);
      step();
      check(16'(o_buffer_half_indicator), 16'h0);
    end
    i_enable = 1'b0;
    i_auto_sample_en = 1'b0;
    i_sample_bit = 1'b0;
    step(4);
  endtask
  task automatic t_single();
    run_seq(1'b0, 4'hf, 16'hffff, 1'b0);
    for (int k = 0; k < 16; k++)
      rd(4'(k), word(1'b0, 4'(k)));
  endtask
  task automatic t_split();
    run_seq(1'b1, 4'h2, 16'h0070, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      rd(4'(k), word(1'b0, 4'(4 + k)));
      rd(4'(8 + k), word(1'b0, 4'(4 + k)));
    end
  endtask
  task automatic t_alt();
    i_mux_b_positive_sel = 4'h9;
    i_mux_b_negative_sel = 1'b1;
    i_conv_clock_prescale = 8'h01;
    run_seq(1'b0, 4'h3, 16'h0003, 1'b1);
    rd(4'h0, word(1'b0, 4'h0));
    rd(4'h1, word(1'b1, 4'h9));
    rd(4'h2, word(1'b0, 4'h1));
    rd(4'h3, word(1'b1, 4'h9));
  endtask
  task automatic t_rc();
    int k;
    i_conv_clock_source_bit = 1'b1;
    i_trigger_source_sel = asb_pkg::TRIG_MANUAL;
    i_scan_enable_bit = 1'b0;
    i_alternate_mux_bit = 1'b0;
    @(posedge i_ref_clk iff i_rc_osc_tick === 1'b1);
    #1;
    check(16'(o_conv_clock), 16'h1);
    i_enable = 1'b1;
    i_sample_bit = 1'b1;
    step(6);
    i_sample_bit = 1'b0;
    wait_hi(1'b0);
    // Busy output lags the start pulse by one cycle
    step();
    for (k = 1; o_converting !== 1'b0 && k < 200; k++)
      step();
    check(16'(k >= 44 && k <= 50), 16'h1);
  endtask
  task automatic final_report();
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    step(2);
    i_arst_n = 1'b1;
    step();
    t_refs();
    t_manual();
    t_triggers();
    t_single();
    t_split();
    t_alt();
    t_rc();
    final_report();
  end
  initial
  begin
    #2000000;
    fail_count++;
    final_report();
  end
endmodule
